// File: ir_link_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the sensor link block.
 * Assumes a 25 MHz bus clock and word-aligned AHB-Lite accesses.
 */
`ifndef IR_LINK_REGS_SVH
`define IR_LINK_REGS_SVH

`define CONFIG_OFF      8'h00
`define FRAME_OFF       8'h04
`define IRQ_STATUS_OFF  8'h08
`define IRQ_CLEAR_OFF   8'h0C
`define IRQ_ENABLE_OFF  8'h10
`define LINK_STATUS_OFF 8'h14

`define CFG_STEP_BIT    6
`define CFG_PSAVE_BIT   7
`define CFG_DONE_BIT    9
`define CONFIG_RESET    16'h0000
`define FRAME_RESET     24'h0186A0

`define IRQ_FRAME_BIT   0
`define IRQ_DONE_BIT    1
`define IRQ_STOP_BIT    2

`define SENSOR_ADDR     7'h60
`define MEMORY_ADDR     7'h50
`define CMD_LOW_BYTE    8'h01
`define CMD_HIGH_BYTE   8'h08

`define CLK_MHZ         25
`define START_DELAY_US  5000
`define START_CYCLES    (`START_DELAY_US * `CLK_MHZ)

`endif

// File: ir_link_pkg.sv
/*
 * Types shared by the sensor link block.
 * Assumes nothing of its surroundings.
 */
package ir_link_pkg;

    typedef enum logic [2:0]
    {
        LS_IDLE  = 3'b000,
        LS_ADDR  = 3'b001,
        LS_AACK  = 3'b010,
        LS_WDATA = 3'b011,
        LS_WACK  = 3'b100,
        LS_RDATA = 3'b101,
        LS_RACK  = 3'b110
    } link_state_t;

endpackage : ir_link_pkg

// File: pin_sync.sv
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to hclk.
 */
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] stage_one;

    // Pins idle high on an open-drain bus
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stage_one    <= '1;
            pin_sync_out <= '1;
        end
        else
        begin
            stage_one    <= pin;
            pin_sync_out <= stage_one;
        end
    end

endmodule : pin_sync

// File: ir_link.sv
/*
 * Two-wire slave front end and mode control of a thermal pixel sensor,
 * with an AHB-Lite register slave and one level interrupt.
 * Assumes scl and sda come straight from pins; the bench resolves the
 * open-drain wire from sda_oe.
 */
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
// Summary of operation
// - Respond on the link only after about 5 ms from reset release.
// - Slave only; sensor link up to 1 MHz, memory up to 400 kHz.
// - Open-drain data: drive low for zero, release for one.
// - Data changes only while clock low; changes in clock high mark framing.
// - Sessions open with start and close with stop; both detected.
// - Seven address bits then direction bit, high means master reads.
// - Two slave addresses answered: sensor and calibration memory; the memory address is not answered while in power saving.
// - Ninth clock: transmitter releases, receiver pulls low to acknowledge.
// - Normal mode refreshes results once every frame period.
// - Normal mode gives the master access to all functions.
// - Step mode selected by configuration; started by command.
// - Step measurement starts only at the stop ending the session.
// - Step measurement lasts one frame period.
// - Commands during a step measurement are acknowledged but ignored.
// - Configuration bit 9 flags a finished step measurement.
// - Configuration bit 7 enters power saving; oscillator stopped.
// - Start wakes oscillator; non-matching address stops it again.
`timescale 1ns/1ns
`include "ir_link_regs.svh"
module ir_link #(
    parameter int START_DELAY = `START_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             osc_enable,
    output logic             frame_tick,
    output logic             irq
);
    import ir_link_pkg::*;

    logic        [1:0]  pins;
    logic               scl_s;
    logic               sda_s;
    logic               scl_d;
    logic               sda_d;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_det;
    logic               stop_det;
    link_state_t        state;
    logic        [3:0]  bit_cnt;
    logic        [7:0]  shift;
    logic               rw;
    logic               to_sensor;
    logic        [1:0]  byte_idx;
    logic               cmd_seen;
    logic               ready;
    logic        [31:0] start_cnt;
    logic        [15:0] config_reg;
    logic        [23:0] frame_period;
    logic        [23:0] frame_cnt;
    logic               busy;
    logic               meas_done;
    logic               step_end;
    logic               launch;
    logic        [2:0]  irq_status;
    logic        [2:0]  irq_enable;
    logic        [2:0]  events;
    logic               wr_pend;
    logic        [7:0]  wr_addr;
    logic               awake;
    logic        [7:0]  tx_byte;
    logic               rd_hi;

    pin_sync #(.WIDTH(2)) u_sync (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .pin          ({scl_in, sda_in}),
        .pin_sync_out (pins)
    );

    assign scl_s = pins[1];
    assign sda_s = pins[0];

    // Edge finder on the synchronised pins; scl is only ever sampled
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise  = scl_s && !scl_d;
    assign scl_fall  = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

    // Start-up hold-off after reset release
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_cnt <= 32'h00000000;
            ready     <= 1'b0;
        end
        else if (!ready)
        begin
            start_cnt <= start_cnt + 32'h00000001;
            ready     <= (start_cnt >= 32'(START_DELAY - 1));
        end
    end

    // Outgoing byte: configuration word, low byte then high byte
    assign tx_byte = rd_hi ? {config_reg[15:10], meas_done, config_reg[8]}
                           : config_reg[7:0];

    // Link state machine
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state     <= LS_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            rw        <= 1'b0;
            to_sensor <= 1'b0;
            byte_idx  <= 2'h0;
            sda_oe    <= 1'b0;
            rd_hi     <= 1'b0;
        end
        else if (stop_det)
        begin
            state  <= LS_IDLE;
            sda_oe <= 1'b0;
        end
        else if (start_det && ready)
        begin
            state    <= LS_ADDR;
            bit_cnt  <= 4'h0;
            byte_idx <= 2'h0;
            rd_hi    <= 1'b0;
            sda_oe   <= 1'b0;
        end
        else
        begin
            case (state)
                LS_IDLE:
                begin
                    sda_oe <= 1'b0;
                end
                LS_ADDR, LS_WDATA:
                begin
                    if (scl_rise && bit_cnt < 4'h8)
                    begin
                        shift   <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (scl_fall && bit_cnt == 4'h8)
                    begin
                        bit_cnt <= 4'h0;
                        if (state == LS_WDATA)
                        begin
                            state  <= LS_WACK;
                            sda_oe <= 1'b1;
                            if (byte_idx != 2'h3)
                                byte_idx <= byte_idx + 2'h1;
                        end
                        else if (shift[7:1] == `SENSOR_ADDR ||
                                 (shift[7:1] == `MEMORY_ADDR &&
                                  !config_reg[`CFG_PSAVE_BIT]))
                        begin
                            state     <= LS_AACK;
                            rw        <= shift[0];
                            to_sensor <= (shift[7:1] == `SENSOR_ADDR);
                            sda_oe    <= 1'b1;
                        end
                        else
                            state <= LS_IDLE;
                    end
                end
                LS_AACK, LS_WACK:
                begin
                    if (scl_fall)
                    begin
                        if (rw)
                        begin
                            state  <= LS_RDATA;
                            shift  <= tx_byte;
                            sda_oe <= !tx_byte[7];
                        end
                        else
                        begin
                            state  <= LS_WDATA;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                LS_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt == 4'h7)
                        begin
                            state   <= LS_RACK;
                            bit_cnt <= 4'h0;
                            sda_oe  <= 1'b0;
                            rd_hi   <= !rd_hi;
                        end
                        else
                        begin
                            bit_cnt <= bit_cnt + 4'h1;
                            shift   <= {shift[6:0], 1'b0};
                            sda_oe  <= !shift[6];
                        end
                    end
                end
                LS_RACK:
                begin
                    if (scl_rise && sda_s)
                        state <= LS_IDLE;
                    else if (scl_fall)
                    begin
                        state  <= LS_RDATA;
                        shift  <= tx_byte;
                        sda_oe <= !tx_byte[7];
                    end
                end
                default:
                begin
                    state  <= LS_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;

    // Start-measure command capture; held until the next start, stop or a third data byte
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cmd_seen <= 1'b0;
        else if (stop_det || start_det)
            cmd_seen <= 1'b0;
        else if (state == LS_WDATA && scl_fall && bit_cnt == 4'h8 &&
                 to_sensor && !rw)
        begin
            if (byte_idx == 2'h0)
                cmd_seen <= (shift == `CMD_LOW_BYTE);
            else if (byte_idx == 2'h1)
                cmd_seen <= cmd_seen && (shift == `CMD_HIGH_BYTE);
            else
                cmd_seen <= 1'b0;
        end
    end

    // Step launch at stop, ignored while busy
    assign launch = stop_det && cmd_seen && byte_idx == 2'h2 &&
                    config_reg[`CFG_STEP_BIT] && !busy;

    // Frame timer shared by normal and step mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            frame_cnt  <= 24'h000000;
            frame_tick <= 1'b0;
            busy       <= 1'b0;
        end
        else
        begin
            frame_tick <= 1'b0;
            if (launch)
            begin
                busy      <= 1'b1;
                frame_cnt <= 24'h000000;
            end
            else if (config_reg[`CFG_PSAVE_BIT] ||
                     (config_reg[`CFG_STEP_BIT] && !busy))
                frame_cnt <= 24'h000000;
            else if (frame_cnt >= frame_period - 24'h000001)
            begin
                frame_cnt  <= 24'h000000;
                frame_tick <= 1'b1;
                busy       <= 1'b0;
            end
            else
                frame_cnt <= frame_cnt + 24'h000001;
        end
    end

    // Last cycle of a running step measurement
    assign step_end = busy && !config_reg[`CFG_PSAVE_BIT] &&
                      frame_cnt >= frame_period - 24'h000001;

    // Completion flag: cleared at launch, set at the end of a step
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            meas_done <= 1'b0;
        else if (step_end)
            meas_done <= 1'b1;
        else if (busy && frame_cnt == 24'h000000)
            meas_done <= meas_done;
        else if (launch)
            meas_done <= 1'b0;
    end

    // Oscillator: off in power saving unless a session is open or a step measurement is running
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            awake <= 1'b0;
        else if (start_det)
            awake <= 1'b1;
        else if (state == LS_IDLE)
            awake <= 1'b0;
    end

    assign osc_enable = !config_reg[`CFG_PSAVE_BIT] || awake || busy;

    // AHB-Lite slave: address phase captured, write in data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata  <= 32'h00000000;
        end
        else
        begin
            wr_pend <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready)
            begin
                wr_addr <= haddr[7:0];
                if (!hwrite)
                begin
                    case (haddr[7:0])
                        `CONFIG_OFF:
                            hrdata <= {16'h0000, config_reg[15:10],
                                       meas_done, config_reg[8:0]};
                        `FRAME_OFF:       hrdata <= {8'h00, frame_period};
                        `IRQ_STATUS_OFF:  hrdata <= {29'h0, irq_status};
                        `IRQ_ENABLE_OFF:  hrdata <= {29'h0, irq_enable};
                        `LINK_STATUS_OFF:
                            hrdata <= {25'h0, ready, busy, awake,
                                       1'b0, state};
                        default:          hrdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // Software registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            config_reg   <= `CONFIG_RESET;
            frame_period <= `FRAME_RESET;
            irq_enable   <= 3'h0;
        end
        else if (wr_pend)
        begin
            case (wr_addr)
                `CONFIG_OFF:     config_reg   <= hwdata[15:0];
                `FRAME_OFF:      frame_period <= hwdata[23:0];
                `IRQ_ENABLE_OFF: irq_enable   <= hwdata[2:0];
                default:         config_reg   <= config_reg;
            endcase
        end
    end

    // Sticky events; a set wins over a clear in the same cycle
    assign events = {stop_det && state != LS_IDLE,
                     step_end, frame_tick};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_status <= 3'h0;
        else if (wr_pend && wr_addr == `IRQ_CLEAR_OFF)
            irq_status <= (irq_status & ~hwdata[2:0]) | events;
        else
            irq_status <= irq_status | events;
    end

    assign irq = |(irq_status & irq_enable);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_no_drive_before_ready;
        !ready |-> !sda_oe;
    endproperty
    a_no_drive_before_ready: assert property (p_no_drive_before_ready)
        else $error("data line driven before start-up delay");

    property p_open_drain_low;
        sda_oe |-> sda_out == 1'b0;
    endproperty
    a_open_drain_low: assert property (p_open_drain_low)
        else $error("data line driven high");

    property p_change_only_clock_low;
        $changed(sda_oe) |-> !scl_d;
    endproperty
    a_change_only_clock_low: assert property (p_change_only_clock_low)
        else $error("data changed while clock high");

    property p_start_to_addr;
        start_det && ready && !stop_det |=> state == LS_ADDR;
    endproperty
    a_start_to_addr: assert property (p_start_to_addr)
        else $error("start not detected");

    property p_stop_to_idle;
        stop_det |=> state == LS_IDLE && !sda_oe;
    endproperty
    a_stop_to_idle: assert property (p_stop_to_idle)
        else $error("stop not detected");

    property p_launch_at_stop;
        launch |-> stop_det ##1 busy && !meas_done;
    endproperty
    a_launch_at_stop: assert property (p_launch_at_stop)
        else $error("step measurement not launched at stop");

    property p_busy_ignores;
        busy && !frame_tick |=> busy && $past(frame_cnt) + 24'h1 == frame_cnt
                                || frame_tick;
    endproperty
    a_busy_ignores: assert property (p_busy_ignores)
        else $error("step measurement restarted while busy");

    property p_done_flag;
        $fell(busy) |-> ##1 meas_done;
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("completion flag not set");

    property p_psave_osc_off;
        state == LS_IDLE && !start_det |=> !awake;
    endproperty
    a_psave_osc_off: assert property (p_psave_osc_off)
        else $error("oscillator running in power saving");

endmodule : ir_link

// File: i2c_master_model.sv
/*
 * Behavioural two-wire bus master that drives the sensor link.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/1ns
module i2c_master_model
(
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    // Clock and data stand released between sessions
    initial
    begin
        scl    = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic start_cond();
        #17 sda_oe = 1'b0;
        scl = 1'b1;
        #80 sda_oe = 1'b1;
        #80 scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        sda_oe = 1'b1;
        #80 scl = 1'b1;
        #80 sda_oe = 1'b0;
        #80;
    endtask : stop_cond

    // One 320 ns clock; data moves only while the clock is low
    task automatic xfer_bit(input logic b, output logic r);
        sda_oe = ~b;
        #80 scl = 1'b1;
        #80 r = sda;
        #80 scl = 1'b0;
        #80;
    endtask : xfer_bit

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask : send_byte

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(~ack, r);
    endtask : recv_byte
endmodule : i2c_master_model

// File: ir_link_tb_top.sv
/*
 * Self-checking bench of the sensor link: AHB-Lite register traffic
 * and a two-wire master model.
 * Assumes the register header and the master model are compiled first.
 */
`timescale 1ns/1ns
`include "ir_link_regs.svh"
module ir_link_tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        scl;
    logic        m_oe;
    logic        sda_out;
    logic        sda_oe;
    logic        osc_enable;
    logic        frame_tick;
    logic        irq;
    logic [31:0] rd;
    logic [15:0] exp_cfg;
    logic        a;
    logic [7:0]  b;
    int          fail_count;
    int          cmp_count;
    int          seed;
    int          n;
    logic [6:0]  adr [3] = '{`SENSOR_ADDR, `MEMORY_ADDR, 7'h33};
    logic [7:0]  cmd [3] = '{{`SENSOR_ADDR, 1'b0}, `CMD_LOW_BYTE,
                             `CMD_HIGH_BYTE};
    // Open-drain wire with pull-up
    wire         sda = ~(m_oe | (sda_oe & ~sda_out));

    ir_link #(.START_DELAY(200)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .osc_enable(osc_enable),
        .frame_tick(frame_tick), .irq(irq));

    i2c_master_model i_mst (.scl(scl), .sda_oe(m_oe), .sda(sda));

    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic ahb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, ad};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic rdchk(input string nm, input logic [7:0] ad,
                         input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, ad, 32'h0);
        chk(nm, e, rd & m);
        chk("resp", 32'h0, {31'h0, hresp});
    endtask : rdchk

    task automatic step_cmd();
        i_mst.start_cond();
        foreach (cmd[i])
        begin
            i_mst.send_byte(cmd[i], a);
            chk("cmd ack", 32'h1, {31'h0, a});
        end
    endtask : step_cmd

    // Cuts a hung run short
    initial
    begin
        #400000;
        fail_count++;
        end_sim();
    end

    initial
    begin
        seed = 32'h15A6;
        fail_count = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("frame rst", `FRAME_OFF, 32'hFFFFFFFF, `FRAME_RESET);
        ahb(1'b1, `FRAME_OFF, 32'h28);
        i_mst.start_cond();
        i_mst.send_byte(cmd[0], a);
        chk("early ack", 32'h0, {31'h0, a});
        i_mst.stop_cond();
        repeat (200) @(posedge hclk);
        rdchk("cfg rst", `CONFIG_OFF, 32'hFFFFFFFF, `CONFIG_RESET);
        exp_cfg = 16'($random(seed)) & 16'hFD3F;
        ahb(1'b1, `CONFIG_OFF, {16'h0, exp_cfg});
        rdchk("cfg rw", `CONFIG_OFF, 32'hFFFFFFFF, {16'h0, exp_cfg});
        ahb(1'b1, 8'h20, 32'hFFFFFFFF);
        rdchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
        rdchk("clear reg", `IRQ_CLEAR_OFF, 32'hFFFFFFFF, 32'h0);
        foreach (adr[i])
        begin
            i_mst.start_cond();
            i_mst.send_byte({adr[i], 1'b0}, a);
            chk("addr ack", {31'h0, i < 2}, {31'h0, a});
            i_mst.stop_cond();
        end
        rdchk("stop seen", `IRQ_STATUS_OFF, 32'h4, 32'h4);
        ahb(1'b1, `IRQ_CLEAR_OFF, 32'h4);
        rdchk("stop clr", `IRQ_STATUS_OFF, 32'h4, 32'h0);
        do @(posedge hclk); while (frame_tick !== 1'b1);
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (frame_tick !== 1'b1);
        chk("frame period", 32'h28, n);
        rdchk("frame irq", `IRQ_STATUS_OFF, 32'h1, 32'h1);
        ahb(1'b1, `CONFIG_OFF, {16'h0, exp_cfg | 16'h0080});
        repeat (4) @(negedge hclk);
        chk("osc off", 32'h0, {31'h0, osc_enable});
        i_mst.start_cond();
        i_mst.send_byte({`MEMORY_ADDR, 1'b0}, a);
        chk("psave mem ack", 32'h0, {31'h0, a});
        i_mst.stop_cond();
        @(negedge hclk);
        chk("osc off again", 32'h0, {31'h0, osc_enable});
        i_mst.start_cond();
        i_mst.send_byte({`SENSOR_ADDR, 1'b1}, a);
        chk("psave ack", 32'h1, {31'h0, a});
        chk("osc on", 32'h1, {31'h0, osc_enable});
        i_mst.recv_byte(1'b1, b);
        chk("rd low", {24'h0, exp_cfg[7:0] | 8'h80}, {24'h0, b});
        i_mst.recv_byte(1'b0, b);
        chk("rd high", {24'h0, exp_cfg[15:8]}, {24'h0, b});
        i_mst.stop_cond();
        ahb(1'b1, `CONFIG_OFF, {16'h0, exp_cfg | 16'h0040});
        ahb(1'b1, `FRAME_OFF, 32'h3E8);
        ahb(1'b1, `IRQ_ENABLE_OFF, 32'h2);
        step_cmd();
        repeat (1100) @(posedge hclk);
        rdchk("idle before stop", `LINK_STATUS_OFF, 32'h20, 32'h0);
        i_mst.stop_cond();
        repeat (8) @(posedge hclk);
        rdchk("busy at stop", `LINK_STATUS_OFF, 32'h20, 32'h20);
        rdchk("flag at stop", `CONFIG_OFF, 32'h200, 32'h0);
        step_cmd();
        i_mst.stop_cond();
        repeat (600) @(posedge hclk);
        rdchk("flag busy", `CONFIG_OFF, 32'h200, 32'h0);
        repeat (300) @(posedge hclk);
        rdchk("flag done", `CONFIG_OFF, 32'h200, 32'h200);
        @(negedge hclk);
        chk("irq on", 32'h1, {31'h0, irq});
        ahb(1'b1, `IRQ_ENABLE_OFF, 32'h0);
        @(negedge hclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdchk("done kept", `IRQ_STATUS_OFF, 32'h2, 32'h2);
        ahb(1'b1, `IRQ_CLEAR_OFF, 32'h2);
        rdchk("done clr", `IRQ_STATUS_OFF, 32'h2, 32'h0);
        end_sim();
    end
endmodule : ir_link_tb_top
